// ### two_wire_master_sequencer.sv
`timescale 1ns/1ns
// Functional notes
// - start waits until bus seen free
// - after START, flag set, status 08
// - writing one clears flag and resumes
// - address direction bit picks transmit or receive
// - after read address, status 38, 40, 48
// - in 40/50 receive byte, ack per enable
// - received byte readable while flag set
// - in 48/58 start, stop, or both
// - status 38: release, or start when free
// - in 28/30 send byte or stop/start
// - stop request bit self-clears after STOP
// - in 10, address picks receive or transmit
// - repeated start keeps bus without STOP
// - data write without flag dropped, collision
// - flag set holds transfer paused
// - after write address, status 18, 20, 38
module two_wire_master_sequencer
    import two_wire_pkg::*;
#(
    parameter int unsigned QUARTER = QUARTER_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic irq_o
);
    two_wire_eng_if eng();

    two_wire_bit_engine #(
        .QUARTER(QUARTER)
    ) u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .eng(eng),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_oe_n_o(scl_oe_n_o),
        .sda_oe_n_o(sda_oe_n_o)
    );

    // open-drain lines only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
        hit = (adr[3:2] == ofs[3:2]);
    endfunction

    function automatic logic is_code(input logic [7:0] st, input logic [7:0] a,
                                     input logic [7:0] b);
        is_code = (st == a) || (st == b);
    endfunction

    // ************************************************************
    // wishbone slave
    // ************************************************************
    logic ack_q;
    logic [31:0] dat_q;
    logic flag_q, ack_en_q, start_q, stop_q, wcol_q, en_q, ie_q, irq_q;
    logic [7:0] status_q, data_q;
    logic [1:0] presc_q;

    // writes land on the edge at which the master sees ack
    wire wr = cyc_i && stb_i && we_i && ack_q && sel_i[0];
    wire wr_byte = wr && hit(adr_i, OFS_BYTE);
    wire wr_state = wr && hit(adr_i, OFS_STATE);
    wire wr_ctl = wr && hit(adr_i, OFS_CONTROL);
    wire [7:0] ctl_rd = {flag_q, ack_en_q, start_q, stop_q, wcol_q, en_q, 1'b0, ie_q};
    wire [7:0] state_rd = {status_q[7:ST_CODE_LSB], 1'b0, presc_q};
    wire [7:0] rd_mux = hit(adr_i, OFS_BYTE) ? data_q :
        hit(adr_i, OFS_STATE) ? state_rd :
        hit(adr_i, OFS_CONTROL) ? ctl_rd : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
            if (cyc_i && stb_i && !ack_q) begin
                dat_q <= {24'h0, rd_mux};
            end
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // ************************************************************
    // sequencer
    // ************************************************************
    seq_e seq_q;
    act_e act_q;
    logic kick_q, go_q, rxm_q, read_mode_q;
    eng_op_e op_q;
    logic [8:0] tx9_q;

    wire owned = is_code(status_q, ST_START, ST_RSTART) || is_code(status_q, ST_AW_ACK, ST_AW_NACK)
        || is_code(status_q, ST_TX_ACK, ST_TX_NACK) || is_code(status_q, ST_AR_ACK, ST_AR_NACK)
        || is_code(status_q, ST_RX_ACK, ST_RX_NACK);
    wire act_e act_pick = stop_q ? (start_q ? A_STOPSTART : A_STOP) :
        start_q ? (owned ? A_RSTART : A_START) :
        is_code(status_q, ST_START, ST_RSTART) ? A_ADDR :
        (is_code(status_q, ST_AW_ACK, ST_AW_NACK) || is_code(status_q, ST_TX_ACK, ST_TX_NACK))
            ? A_TX :
        is_code(status_q, ST_AR_ACK, ST_RX_ACK) ? A_RX : A_NONE;
    wire eng_done = (seq_q == SQ_RUN) && eng.done;
    wire rx_ack = !eng.rx9[0];
    wire stop_done = eng_done && (act_q == A_STOP || act_q == A_STOPSTART);
    wire flag_set = eng_done && !(act_q == A_STOP || act_q == A_STOPSTART);
    wire [7:0] done_code = (act_q == A_START) ? ST_START :
        (act_q == A_RSTART) ? ST_RSTART :
        (act_q == A_RX) ? (tx9_q[0] ? ST_RX_NACK : ST_RX_ACK) :
        eng.arb_lost ? ST_ARB :
        (act_q == A_TX) ? (rx_ack ? ST_TX_ACK : ST_TX_NACK) :
        read_mode_q ? (rx_ack ? ST_AR_ACK : ST_AR_NACK) :
        (rx_ack ? ST_AW_ACK : ST_AW_NACK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kick_q <= 1'b0;
        end else begin
            // a one in the flag bit resumes only from a paused sequencer
            kick_q <= wr_ctl && dat_i[CTL_FLAG] && dat_i[CTL_EN] && seq_q == SQ_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !en_q) begin
            seq_q <= SQ_IDLE;
            act_q <= A_NONE;
            go_q <= 1'b0;
            op_q <= OP_START;
            tx9_q <= 9'h1FF;
            rxm_q <= 1'b0;
            read_mode_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            case (seq_q)
                SQ_IDLE: begin
                    if (kick_q && act_pick != A_NONE) begin
                        act_q <= act_pick;
                        seq_q <= (act_pick == A_START) ? SQ_WAIT_FREE : SQ_RUN;
                        go_q <= (act_pick != A_START);
                        op_q <= (act_pick == A_RSTART) ? OP_START :
                            (act_pick == A_STOP || act_pick == A_STOPSTART) ? OP_STOP : OP_BYTE;
                        rxm_q <= (act_pick == A_RX);
                        // the acknowledge slot carries not-ack when acknowledging is off
                        tx9_q <= (act_pick == A_RX) ? {8'hFF, !ack_en_q} : {data_q, 1'b1};
                        if (act_pick == A_ADDR) begin
                            read_mode_q <= data_q[0];
                        end
                    end
                end
                SQ_WAIT_FREE: begin
                    if (!eng.busy) begin
                        seq_q <= SQ_RUN;
                        go_q <= 1'b1;
                        op_q <= OP_START;
                    end
                end
                SQ_RUN: begin
                    if (eng.done) begin
                        seq_q <= (act_q == A_STOPSTART) ? SQ_WAIT_FREE : SQ_IDLE;
                        act_q <= (act_q == A_STOPSTART) ? A_START : act_q;
                    end
                end
                default: begin
                    seq_q <= SQ_IDLE;
                end
            endcase
        end
    end

    assign eng.en = en_q;
    assign eng.go = go_q;
    assign eng.op = op_q;
    assign eng.tx9 = tx9_q;
    assign eng.rx_mode = rxm_q;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
            status_q <= ST_NONE;
        end else begin
            flag_q <= flag_set || (flag_q && !(wr_ctl && dat_i[CTL_FLAG]));
            if (flag_set) begin
                status_q <= done_code;
            end else if (stop_done || (kick_q && act_pick == A_NONE)) begin
                status_q <= ST_NONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {ack_en_q, start_q, en_q, ie_q} <= 4'h0;
            stop_q <= 1'b0;
            presc_q <= PRESC_RESET;
        end else begin
            if (stop_done) begin
                stop_q <= 1'b0;
            end
            if (wr_ctl) begin
                ack_en_q <= dat_i[CTL_ACK_EN];
                start_q <= dat_i[CTL_START];
                stop_q <= dat_i[CTL_STOP];
                en_q <= dat_i[CTL_EN];
                ie_q <= dat_i[CTL_IE];
            end
            if (wr_state) begin
                presc_q <= dat_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_q <= BYTE_RESET;
            wcol_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && ie_q;
            if (eng_done && act_q == A_RX) begin
                data_q <= eng.rx9[8:1];
            end else if (wr_byte && flag_q) begin
                data_q <= dat_i[7:0];
                wcol_q <= 1'b0;
            end else if (wr_byte) begin
                wcol_q <= 1'b1;
            end
        end
    end
    assign irq_o = irq_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rx_done;
        eng_done && act_q == A_RX;
    endsequence

    sequence s_addr_done;
        eng_done && act_q == A_ADDR && !eng.arb_lost;
    endsequence

    property p_pause;
        flag_q |-> !go_q && seq_q == SQ_IDLE;
    endproperty
    a_pause: assert property (p_pause) else $error("transfer moved while flag set");

    property p_free_start;
        seq_q == SQ_WAIT_FREE && !eng.busy |=> go_q && op_q == OP_START;
    endproperty
    a_free_start: assert property (p_free_start) else $error("start not issued when free");

    property p_start_code;
        eng_done && act_q == A_START |=> flag_q && status_q == ST_START;
    endproperty
    a_start_code: assert property (p_start_code) else $error("start did not report 08");

    property p_rx_byte;
        logic [7:0] b;
        (s_rx_done, b = eng.rx9[8:1]) |=> flag_q && data_q == b
            && (status_q == ST_RX_ACK || status_q == ST_RX_NACK);
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("received byte not presented");

    property p_ack_choice;
        kick_q && act_pick == A_RX |=> go_q && tx9_q[0] == !$past(ack_en_q);
    endproperty
    a_ack_choice: assert property (p_ack_choice) else $error("wrong acknowledge choice");

    property p_mode;
        s_addr_done |=> (read_mode_q ? (status_q == ST_AR_ACK || status_q == ST_AR_NACK)
            : (status_q == ST_AW_ACK || status_q == ST_AW_NACK));
    endproperty
    a_mode: assert property (p_mode) else $error("address direction mode mismatch");

    property p_stop_clear;
        stop_done && !wr_ctl |=> !stop_q && !flag_q;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop request not cleared");

    property p_wcol;
        wr_byte && !flag_q && !eng_done |=> wcol_q && $stable(data_q);
    endproperty
    a_wcol: assert property (p_wcol) else $error("collision write not dropped");

    property p_irq;
        flag_q && ie_q ##1 flag_q && ie_q |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

// ### two_wire_pkg.sv
package two_wire_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_QUARTER_NS = 2500;
    // a least time, so round up to whole cycles
    localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [3:0] OFS_BYTE = 4'h0;
    localparam logic [3:0] OFS_STATE = 4'h4;
    localparam logic [3:0] OFS_CONTROL = 4'h8;
    localparam int CTL_FLAG = 7;
    localparam int CTL_ACK_EN = 6;
    localparam int CTL_START = 5;
    localparam int CTL_STOP = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN = 2;
    localparam int CTL_IE = 0;
    localparam int ST_CODE_LSB = 3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] PRESC_RESET = 2'h0;

    // ************************************************************
    // status codes
    // ************************************************************
    localparam logic [7:0] ST_START = 8'h08;
    localparam logic [7:0] ST_RSTART = 8'h10;
    localparam logic [7:0] ST_AW_ACK = 8'h18;
    localparam logic [7:0] ST_AW_NACK = 8'h20;
    localparam logic [7:0] ST_TX_ACK = 8'h28;
    localparam logic [7:0] ST_TX_NACK = 8'h30;
    localparam logic [7:0] ST_ARB = 8'h38;
    localparam logic [7:0] ST_AR_ACK = 8'h40;
    localparam logic [7:0] ST_AR_NACK = 8'h48;
    localparam logic [7:0] ST_RX_ACK = 8'h50;
    localparam logic [7:0] ST_RX_NACK = 8'h58;
    localparam logic [7:0] ST_NONE = 8'hF8;

    typedef enum logic [1:0] {OP_START, OP_STOP, OP_BYTE} eng_op_e;
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT_FREE, SQ_RUN} seq_e;
    typedef enum logic [2:0] {
        A_NONE, A_START, A_RSTART, A_STOP, A_STOPSTART, A_ADDR, A_TX, A_RX
    } act_e;

endpackage

// ### two_wire_eng_if.sv
`timescale 1ns/1ns
interface two_wire_eng_if;
    import two_wire_pkg::*;
    logic en;
    logic go;
    eng_op_e op;
    logic [8:0] tx9;
    logic rx_mode;
    logic done;
    logic arb_lost;
    logic [8:0] rx9;
    logic busy;
    modport seq (output en, go, op, tx9, rx_mode, input done, arb_lost, rx9, busy);
    modport engine (input en, go, op, tx9, rx_mode, output done, arb_lost, rx9, busy);
endinterface

// ### two_wire_bit_engine.sv
`timescale 1ns/1ns
module two_wire_bit_engine
    import two_wire_pkg::*;
#(
    parameter int unsigned QUARTER = QUARTER_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    two_wire_eng_if.engine eng,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_n_o,
    output logic sda_oe_n_o
);
    localparam int TW = (QUARTER > 2) ? $clog2(QUARTER) : 1;
    localparam logic [TW-1:0] T_LAST = TW'(QUARTER - 1);

    if (QUARTER < 2) begin : g_bad_quarter
        $error("quarter bit period must be at least two cycles");
    end

    // ************************************************************
    // line synchronisers and bus-free watch
    // ************************************************************
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q, busy_q;
    wire start_seen = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    wire stop_seen = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            busy_q <= 1'b0;
        end else begin
            {scl_p_q, scl_s_q, scl_m_q} <= {scl_s_q, scl_m_q, scl_i};
            {sda_p_q, sda_s_q, sda_m_q} <= {sda_s_q, sda_m_q, sda_i};
            if (start_seen) begin
                busy_q <= 1'b1;
            end else if (stop_seen) begin
                busy_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // four quarter phases per bit, start or stop
    // ************************************************************
    logic active_q, rxm_q, done_q, arb_q, scl_oe_n_q, sda_oe_n_q;
    eng_op_e op_q;
    logic [1:0] phase_q;
    logic [TW-1:0] timer_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q, rx_q;

    // a slave may stretch the clock: phase 1 ends only once scl reads high
    wire tick = active_q && (timer_q == T_LAST) && (phase_q != 2'd1 || scl_s_q);
    wire arb_hit = tick && phase_q == 2'd1 && op_q == OP_BYTE && !rxm_q
        && bit_q < 4'd8 && sda_oe_n_q && !sda_s_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !active_q || tick) begin
            timer_q <= '0;
        end else if (timer_q != T_LAST) begin
            timer_q <= timer_q + TW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !eng.en) begin
            active_q <= 1'b0;
            done_q <= 1'b0;
            arb_q <= 1'b0;
            rxm_q <= 1'b0;
            op_q <= OP_START;
            phase_q <= 2'd0;
            bit_q <= 4'd0;
            sh_q <= '0;
            rx_q <= '0;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            done_q <= 1'b0;
            if (!active_q) begin
                if (eng.go) begin
                    active_q <= 1'b1;
                    op_q <= eng.op;
                    rxm_q <= eng.rx_mode;
                    sh_q <= eng.tx9;
                    phase_q <= 2'd0;
                    bit_q <= 4'd0;
                    arb_q <= 1'b0;
                    sda_oe_n_q <= (eng.op == OP_STOP) ? 1'b0 :
                        (eng.op == OP_START) ? 1'b1 : eng.tx9[8];
                end
            end else if (arb_hit) begin
                // lost the bus: let go of both lines at once
                active_q <= 1'b0;
                done_q <= 1'b1;
                arb_q <= 1'b1;
                scl_oe_n_q <= 1'b1;
                sda_oe_n_q <= 1'b1;
            end else if (tick) begin
                phase_q <= phase_q + 2'd1;
                case (phase_q)
                    2'd0: begin
                        scl_oe_n_q <= 1'b1;
                    end
                    2'd1: begin
                        if (op_q == OP_START) begin
                            sda_oe_n_q <= 1'b0;
                        end else if (op_q == OP_STOP) begin
                            sda_oe_n_q <= 1'b1;
                        end else begin
                            rx_q <= {rx_q[7:0], sda_s_q};
                        end
                    end
                    2'd2: begin
                        if (op_q != OP_STOP) begin
                            scl_oe_n_q <= 1'b0;
                        end
                    end
                    default: begin
                        if (op_q == OP_BYTE && bit_q != 4'd8) begin
                            bit_q <= bit_q + 4'd1;
                            sh_q <= {sh_q[7:0], 1'b1};
                            sda_oe_n_q <= sh_q[7];
                        end else begin
                            active_q <= 1'b0;
                            done_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign eng.done = done_q;
    assign eng.arb_lost = arb_q;
    assign eng.rx9 = rx_q;
    assign eng.busy = busy_q;
    assign scl_oe_n_o = scl_oe_n_q;
    assign sda_oe_n_o = sda_oe_n_q;
endmodule

// ### two_wire_slave_model.sv
`timescale 1ns/1ns
module two_wire_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] tx_i,
    input wire logic stretch_i,
    output logic sda_pull_o,
    output logic scl_pull_o,
    output logic mack_o,
    output logic [7:0] rx_o
);
    int bitn = -1;
    logic first = 1'b0;
    logic on = 1'b0;
    logic rd = 1'b0;
    logic hit;
    initial mack_o = 1'b0;
    initial scl_pull_o = 1'b0;
    initial rx_o = 8'h00;
    assign hit = first && rx_o[7:1] == ADDR;
    // value follows tx_i live, so the bench may load it while the clock is held low
    assign sda_pull_o = (bitn == 8) ? (hit || (on && !rd && !first)) :
        (on && rd && !first && bitn >= 0 && !tx_i[7 - bitn]);
    always @(negedge sda_i) if (scl_i) begin
        bitn = -1;
        first = 1'b1;
        on = 1'b0;
    end
    always @(posedge sda_i) if (scl_i) begin
        bitn = -1;
        first = 1'b0;
        on = 1'b0;
    end
    always @(posedge scl_i) begin
        if (bitn == 8) mack_o = sda_i;
        else rx_o = {rx_o[6:0], sda_i};
    end
    always @(negedge scl_i) begin
        if (bitn == 8) begin
            if (hit) begin
                on = 1'b1;
                rd = rx_o[0];
                mack_o = 1'b0;
            end else if (rd && mack_o) on = 1'b0;
            first = 1'b0;
            bitn = 0;
        end else bitn = bitn + 1;
    end
    // slow answer: hold the clock low after each falling edge
    always @(negedge scl_i) if (stretch_i) begin
        scl_pull_o = 1'b1;
        #1500 scl_pull_o = 1'b0;
    end
endmodule

// ### tb_two_wire_master_sequencer.sv
`timescale 1ns/1ns
module tb_two_wire_master_sequencer;
    import two_wire_pkg::*;
    localparam logic [6:0] SLV = 7'h2A;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic stretch = 1'b0;
    // a competing master holding sda low
    logic grab = 1'b0;
    logic scl_o, sda_o;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, scl_oe_n, sda_oe_n, irq_o, s_sda, s_scl, mack;
    logic [7:0] tx = 8'h00;
    logic [7:0] q, b, rx;
    wire scl_w = (scl_oe_n | scl_o) & ~s_scl;
    wire sda_w = (sda_oe_n | sda_o) & ~s_sda & ~grab;
    int n_errors = 0;
    int cmp_count = 0;
    int seed;
    logic [7:0] expq[$];

    two_wire_master_sequencer #(.QUARTER(2)) uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
        .dat_i(dat), .dat_o(dat_o), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb),
        .ack_o(ack_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .irq_o(irq_o));
    two_wire_slave_model #(.ADDR(SLV)) slave (.scl_i(scl_w), .sda_i(sda_w), .tx_i(tx),
        .stretch_i(stretch), .sda_pull_o(s_sda), .scl_pull_o(s_scl), .mack_o(mack),
        .rx_o(rx));

    initial forever #25 clk_i = ~clk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        sel <= 4'hF;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // poll until the flag rises, or until the idle status shows after a stop
    task automatic wait_st(input logic [7:0] st);
        do begin
            wb(st == ST_NONE ? OFS_STATE : OFS_CONTROL, 1'b0, 8'h00);
        end while (st == ST_NONE ? (q & 8'hF8) !== ST_NONE : q[CTL_FLAG] !== 1'b1);
        wb(OFS_STATE, 1'b0, 8'h00);
        chk(q & 8'hF8, st);
    endtask

    initial begin
        #3000000;
        n_errors++;
        finish_test;
    end

    initial begin
        seed = $urandom(52);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(OFS_BYTE, 1'b0, 8'h00); chk(q, BYTE_RESET);
        wb(OFS_STATE, 1'b0, 8'h00); chk(q, ST_NONE);
        wb(OFS_CONTROL, 1'b0, 8'h00); chk(q, 8'h00);
        wb(4'hC, 1'b0, 8'h00); chk(q, 8'h00);
        // prescaler bits stay set, so every later status read must mask them
        wb(OFS_STATE, 1'b1, 8'h03);
        wb(OFS_STATE, 1'b0, 8'h00); chk(q, ST_NONE | 8'h03);
        wb(OFS_BYTE, 1'b1, 8'h5A);
        wb(OFS_CONTROL, 1'b0, 8'h00); chk(q[CTL_WCOL], 1'b1);
        wb(OFS_BYTE, 1'b0, 8'h00); chk(q, 8'h00);
        wb(OFS_CONTROL, 1'b1, 8'hA5); wait_st(ST_START);
        chk(irq_o, 1'b1);
        wb(OFS_BYTE, 1'b1, {SLV, 1'b1});
        wb(OFS_CONTROL, 1'b1, 8'hC4); wait_st(ST_AR_ACK);
        chk(irq_o, 1'b0);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            tx <= b;
            expq.push_back(b);
            stretch <= i[0];
            wb(OFS_CONTROL, 1'b1, i == 2 ? 8'h84 : 8'hC4);
            wait_st(i == 2 ? ST_RX_NACK : ST_RX_ACK);
            chk(mack, i == 2);
            wb(OFS_BYTE, 1'b0, 8'h00); chk(q, expq.pop_front());
        end
        wb(OFS_CONTROL, 1'b1, 8'hA4); wait_st(ST_RSTART);
        wb(OFS_BYTE, 1'b1, {SLV, 1'b0});
        wb(OFS_CONTROL, 1'b1, 8'h84); wait_st(ST_AW_ACK);
        b = 8'($urandom);
        wb(OFS_BYTE, 1'b1, b);
        wb(OFS_CONTROL, 1'b1, 8'h84); wait_st(ST_TX_ACK);
        chk(rx, b);
        wb(OFS_CONTROL, 1'b1, 8'h94); wait_st(ST_NONE);
        wb(OFS_CONTROL, 1'b0, 8'h00); chk(q[CTL_STOP], 1'b0);
        chk({scl_w, sda_w}, 2'b11);
        wb(OFS_CONTROL, 1'b1, 8'hA4); wait_st(ST_START);
        wb(OFS_BYTE, 1'b1, {SLV, 1'b1});
        grab <= 1'b1;
        wb(OFS_CONTROL, 1'b1, 8'h84); wait_st(ST_ARB);
        chk({scl_oe_n, sda_oe_n}, 2'b11);
        grab <= 1'b0;
        wb(OFS_CONTROL, 1'b1, 8'hA4); wait_st(ST_START);
        wb(OFS_BYTE, 1'b1, {~SLV, 1'b1});
        wb(OFS_CONTROL, 1'b1, 8'h84); wait_st(ST_AR_NACK);
        wb(OFS_CONTROL, 1'b1, 8'hB4); wait_st(ST_START);
        wb(OFS_CONTROL, 1'b1, 8'h94); wait_st(ST_NONE);
        finish_test;
    end
endmodule
